/* core/debug_mailbox_port.sv */
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps

//Behaviour
// - instruction is four bits, last four kept
// - code field bits 15:12, A interrupt, F bypass
// - instruction reads code, low zero, test-reset bypass
// - status bit 9 one, only flag writable
// - status shifts out flag first, never loaded
// - flag is one after test reset
// - flag zero: CPU owns data; one: shifting
// - data shift keeps last 32 bits
// - data enters bit 31, leaves bit 0
// - data halves CPU read/write, never reset
// - bypass is one shift stage, no CPU access
// - loading interrupt code raises interrupt request
// - finished data shift clears flag
// - flag set by test reset, CPU, bypass
// - update switches status/data path on flag
// - port reset by pin, TMS, stop, standby
// - standby keeps data and stop bit; standby and test reset give bypass
// - output launched on test clock rising edge
// - mode select and input sampled on rise
// - output undriven unless shifting out
module debug_mailbox_port
   import debug_port_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_tck,
   input  wire logic        i_tms,
   input  wire logic        i_tdi,
   input  wire logic        i_trst_n,
   input  wire logic        i_hw_standby,
   output logic             o_tdo,
   output logic             o_tdo_oe,
   output logic             o_debug_irq,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr
);

   logic        core_rst_n;
   test_pins_t  pins_raw;
   test_pins_t  pins;
   tap_state_t  tap_now;
   tap_state_t  tap_next;
   port_regs_t  q;
   port_regs_t  d;
   logic        tck_rise;
   logic        port_reset;
   logic        tap_reset;
   logic        setup;
   logic        access;
   logic        wr;
   logic [5:0]  idx;
   logic        mapped;
   logic        data_path;
   logic [15:0] status_word;
   logic [31:0] rd_word;

   pin_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b0)
   ) u_rst_sync (
      .i_core_clk (i_core_clk),
      .i_arst_n   (i_arst_n),
      .i_async    (1'b1),
      .o_sync     (core_rst_n)
   );

   assign pins_raw.hw_standby = i_hw_standby;
   assign pins_raw.trst_n     = i_trst_n;
   assign pins_raw.tdi        = i_tdi;
   assign pins_raw.tms        = i_tms;
   assign pins_raw.tck        = i_tck;

   pin_sync #(
      .WIDTH     ($bits(test_pins_t)),
      .RESET_VAL (PINS_IDLE)
   ) u_pin_sync (
      .i_core_clk (i_core_clk),
      .i_arst_n   (i_arst_n),
      .i_async    (pins_raw),
      .o_sync     (pins)
   );

   assign tck_rise = pins.tck & ~q.tck_prev;

   assign port_reset = ~pins.trst_n | q.mstop | pins.hw_standby;
   assign tap_reset  = port_reset | ~core_rst_n;

   tap_fsm u_tap (
      .i_core_clk (i_core_clk),
      .i_reset    (tap_reset),
      .i_step     (tck_rise),
      .i_tms      (pins.tms),
      .o_state    (tap_now),
      .o_next     (tap_next)
   );

   assign status_word = STAT_FIXED | {15'h0000, q.flag};

   // data path only after flag one was seen
   assign data_path = (q.instr == CODE_DEBUG_IRQ) & q.sel_data;

   assign setup  = i_psel & ~i_penable;
   assign access = i_psel & i_penable;
   assign wr     = access & i_pwrite & mapped;
   assign idx    = i_paddr[7:2];
   assign mapped = (i_paddr[1:0] == 2'h0) && (idx <= IDX_MODULE_STOP);

   always_comb begin
      case (idx)
         IDX_INSTRUCTION: rd_word = {16'h0000, q.instr, 12'h000};
         IDX_STATUS:      rd_word = {16'h0000, status_word};
         IDX_DATA_HIGH:   rd_word = {16'h0000, q.data[31:16]};
         IDX_DATA_LOW:    rd_word = {16'h0000, q.data[15:0]};
         IDX_MODULE_STOP: rd_word = {31'h0, q.mstop};
         default:         rd_word = 32'h00000000;
      endcase
   end

   always_comb begin
      d          = q;
      d.tck_prev = pins.tck;
      d.irq      = 1'b0;

      if (tck_rise) begin
         // bypass on entry to controller reset
         if (tap_next == TAP_RESET && tap_now != TAP_RESET) begin
            d.instr    = CODE_BYPASS;
            d.sel_data = 1'b0;
         end
         case (tap_now)
            TAP_CAP_IR: begin
               d.ir_shift = IR_CAPTURE;
            end
            TAP_SHIFT_IR: begin
               d.ir_shift = {pins.tdi, q.ir_shift[3:1]};
            end
            TAP_UPDATE_IR: begin
               d.instr = q.ir_shift;
               if (q.ir_shift == CODE_DEBUG_IRQ) begin
                  d.irq = 1'b1;
               end
            end
            TAP_CAP_DR: begin
               d.bypass     = 1'b0;
               d.stat_shift = status_word;
               d.cap_flag   = q.flag;
            end
            TAP_SHIFT_DR: begin
               if (q.instr != CODE_DEBUG_IRQ) begin
                  d.bypass = pins.tdi;
               end else if (data_path) begin
                  // in at top, out at bottom
                  d.data = {pins.tdi, q.data[31:1]};
               end else begin
                  d.stat_shift = {1'b0, q.stat_shift[15:1]};
               end
            end
            TAP_UPDATE_DR: begin
               if (q.instr == CODE_DEBUG_IRQ) begin
                  if (data_path) begin
                     // flag zero means cpu owns data
                     // finished shift hands data to cpu
                     d.flag     = 1'b0;
                     d.sel_data = 1'b0;
                  end else if (q.cap_flag) begin
                     // flag one seen, switch to data
                     d.sel_data = 1'b1;
                  end
               end
            end
            default: begin
               d.ir_shift = d.ir_shift;
            end
         endcase

         d.tdo_oe = (tap_next == TAP_SHIFT_IR) ||
                    (tap_next == TAP_SHIFT_DR);
         if (tap_next == TAP_SHIFT_IR) begin
            d.tdo = d.ir_shift[0];
         end else if (d.instr != CODE_DEBUG_IRQ) begin
            d.tdo = d.bypass;
         end else if (d.instr == CODE_DEBUG_IRQ && d.sel_data) begin
            d.tdo = d.data[0];
         end else begin
            d.tdo = d.stat_shift[0];
         end
      end

      // register bus: read data latched during setup
      if (setup) begin
         d.prdata  = mapped ? rd_word : 32'h00000000;
         d.pslverr = ~mapped;
      end

      if (wr) begin
         case (idx)
            IDX_STATUS: begin
               // only the flag takes a write
               // cpu sets flag after using data
               d.flag = i_pwdata[FLAG_BIT];
            end
            IDX_DATA_HIGH: begin
               d.data[31:16] = i_pwdata[15:0];
            end
            IDX_DATA_LOW: begin
               d.data[15:0] = i_pwdata[15:0];
            end
            IDX_MODULE_STOP: begin
               d.mstop = i_pwdata[STOP_BIT];
            end
            default: begin
               d.mstop = d.mstop;
            end
         endcase
      end

      // bypass holds flag set; sets win
      if (q.instr == CODE_BYPASS) begin
         d.flag = 1'b1;
      end

      // test reset gives bypass, data kept
      if (port_reset) begin
         // initialised to bypass and flag one
         d.instr      = CODE_BYPASS;
         d.flag       = FLAG_RESET;
         d.ir_shift   = IR_CAPTURE;
         d.stat_shift = STAT_FIXED;
         d.sel_data   = 1'b0;
         d.cap_flag   = 1'b0;
         d.bypass     = 1'b0;
         d.tdo        = 1'b0;
         d.tdo_oe     = 1'b0;
         d.irq        = 1'b0;
      end

      // system reset leaves instruction, flag and data alone
      if (!core_rst_n) begin
         d.tck_prev = 1'b1;
         d.mstop    = 1'b0;
         d.irq      = 1'b0;
         d.tdo      = 1'b0;
         d.tdo_oe   = 1'b0;
         d.prdata   = 32'h00000000;
         d.pslverr  = 1'b0;
      end
   end

   // no async reset: test registers must survive system reset
   always_ff @(posedge i_core_clk) begin
      q <= d;
   end

   assign o_tdo       = q.tdo;
   assign o_tdo_oe    = q.tdo_oe;
   assign o_debug_irq = q.irq;
   assign o_prdata    = q.prdata;
   // zero wait states: answer in the first access cycle
   assign o_pready    = 1'b1;
   assign o_pslverr   = q.pslverr;

endmodule : debug_mailbox_port

/* core/debug_port_pkg.sv */
package debug_port_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0]  IDX_INSTRUCTION  = 6'h00;
   localparam logic [5:0]  IDX_STATUS       = 6'h01;
   localparam logic [5:0]  IDX_DATA_HIGH    = 6'h02;
   localparam logic [5:0]  IDX_DATA_LOW     = 6'h03;
   localparam logic [5:0]  IDX_MODULE_STOP  = 6'h04;

   // field positions and fixed values
   localparam int          INSTR_LSB        = 12;
   localparam int          STAT_ONE_BIT     = 9;
   localparam int          FLAG_BIT         = 0;
   localparam int          STOP_BIT         = 0;
   localparam logic [3:0]  CODE_DEBUG_IRQ   = 4'hA;
   localparam logic [3:0]  CODE_BYPASS      = 4'hF;
   localparam logic [3:0]  IR_CAPTURE       = 4'h1;
   localparam logic        FLAG_RESET       = 1'b1;
   localparam logic [15:0] STAT_FIXED       = 16'h0200;

   typedef enum logic [15:0] {
      TAP_RESET      = 16'h0001,
      TAP_IDLE       = 16'h0002,
      TAP_SEL_DR     = 16'h0004,
      TAP_CAP_DR     = 16'h0008,
      TAP_SHIFT_DR   = 16'h0010,
      TAP_EXIT1_DR   = 16'h0020,
      TAP_PAUSE_DR   = 16'h0040,
      TAP_EXIT2_DR   = 16'h0080,
      TAP_UPDATE_DR  = 16'h0100,
      TAP_SEL_IR     = 16'h0200,
      TAP_CAP_IR     = 16'h0400,
      TAP_SHIFT_IR   = 16'h0800,
      TAP_EXIT1_IR   = 16'h1000,
      TAP_PAUSE_IR   = 16'h2000,
      TAP_EXIT2_IR   = 16'h4000,
      TAP_UPDATE_IR  = 16'h8000
   } tap_state_t;

   typedef struct packed {
      logic hw_standby;
      logic trst_n;
      logic tdi;
      logic tms;
      logic tck;
   } test_pins_t;

   localparam test_pins_t PINS_IDLE = 5'h0F;

   typedef struct packed {
      tap_state_t state;
   } tap_regs_t;

   typedef struct packed {
      logic        tck_prev;
      logic [3:0]  instr;
      logic [3:0]  ir_shift;
      logic [31:0] data;
      logic [15:0] stat_shift;
      logic        bypass;
      logic        flag;
      logic        sel_data;
      logic        cap_flag;
      logic        irq;
      logic        tdo;
      logic        tdo_oe;
      logic        mstop;
      logic [31:0] prdata;
      logic        pslverr;
   } port_regs_t;

endpackage : debug_port_pkg

/* core/pin_sync.sv */
`timescale 1ns/100ps

module pin_sync #(
   parameter int                  WIDTH     = 1,
   parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_arst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : pin_sync

/* core/tap_fsm.sv */
`timescale 1ns/100ps

module tap_fsm
   import debug_port_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_step,
   input  wire logic        i_tms,
   output tap_state_t       o_state,
   output tap_state_t       o_next
);
   tap_regs_t q;
   tap_regs_t d;
   tap_state_t nxt;

   always_comb begin
      case (q.state)
         TAP_RESET:     nxt = i_tms ? TAP_RESET   : TAP_IDLE;
         TAP_IDLE:      nxt = i_tms ? TAP_SEL_DR  : TAP_IDLE;
         TAP_SEL_DR:    nxt = i_tms ? TAP_SEL_IR  : TAP_CAP_DR;
         TAP_CAP_DR:    nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR:  nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR:  nxt = i_tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR:  nxt = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR:  nxt = i_tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
         TAP_UPDATE_DR: nxt = i_tms ? TAP_SEL_DR  : TAP_IDLE;
         TAP_SEL_IR:    nxt = i_tms ? TAP_RESET   : TAP_CAP_IR;
         TAP_CAP_IR:    nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR:  nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR:  nxt = i_tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR:  nxt = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR:  nxt = i_tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
         TAP_UPDATE_IR: nxt = i_tms ? TAP_SEL_DR  : TAP_IDLE;
         default:       nxt = TAP_RESET;
      endcase
   end

   always_comb begin
      d = q;
      if (i_reset) begin
         d.state = TAP_RESET;
      end else if (i_step) begin
         d.state = nxt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      q <= d;
   end

   assign o_state = q.state;
   assign o_next  = i_reset ? TAP_RESET : nxt;
endmodule : tap_fsm

/* verif/debug_mailbox_port_asserts.sv */
`timescale 1ns/100ps
module debug_mailbox_port_asserts
   import debug_port_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_arst_n,
   input wire logic        i_tck,
   input wire logic        i_tms,
   input wire logic        i_tdi,
   input wire logic        i_trst_n,
   input wire logic        i_hw_standby,
   input wire logic        o_tdo,
   input wire logic        o_tdo_oe,
   input wire logic        o_debug_irq,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   sequence rd_setup(logic [7:0] a);
      i_psel && !i_penable && !i_pwrite && i_paddr == a;
   endsequence
   sequence wr_flag_one;
      i_psel && i_penable && i_pwrite && i_paddr == {IDX_STATUS, 2'b00}
         && i_pwdata[0];
   endsequence

   AST_INSTR_LOW: assert property (
      rd_setup({IDX_INSTRUCTION, 2'b00}) |=> o_prdata[11:0] == 12'h000
         && o_prdata[31:16] == 16'h0000 && !o_pslverr)
      else $error("instruction read has stray bits");
   AST_STAT_FIXED: assert property (
      rd_setup({IDX_STATUS, 2'b00}) |=>
         (o_prdata & 32'hFFFFFFFE) == 32'h00000200)
      else $error("status fixed bits wrong");
   AST_DATA_HALF: assert property (
      rd_setup({IDX_DATA_LOW, 2'b00}) |=> o_prdata[31:16] == 16'h0000)
      else $error("data half has upper bits");
   AST_UNMAPPED: assert property (
      i_psel && !i_penable && (i_paddr[1:0] != 2'h0 || i_paddr > 8'h10)
         |=> o_pslverr && o_prdata == 32'h00000000)
      else $error("unmapped access not refused");
   AST_FLAG_SET: assert property (
      wr_flag_one ##1 !i_psel ##1 rd_setup({IDX_STATUS, 2'b00})
         |=> o_prdata[0])
      else $error("flag not set by write of one");
   AST_IRQ_PULSE: assert property (
      $rose(o_debug_irq) |=> !o_debug_irq)
      else $error("interrupt request longer than one cycle");
   AST_OE_QUIET: assert property (
      !i_trst_n [*5] |-> !o_tdo_oe)
      else $error("output driven during test reset");
   AST_TDO_LAUNCH: assert property (
      $changed(o_tdo) && o_tdo_oe && $past(o_tdo_oe)
         |-> $past(i_tck, 2) && $past(i_tck, 3))
      else $error("output bit not launched from clock rise");
   AST_OE_LAUNCH: assert property (
      $rose(o_tdo_oe) |-> $past(i_tck, 2) && $past(i_tck, 3))
      else $error("shift start not on clock rise");
endmodule : debug_mailbox_port_asserts

/* verif/jtag_host_model.sv */
`timescale 1ns/100ps
module jtag_host_model (
   input  wire logic i_core_clk,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe,
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_trst_n
);
   // pulled-up pins idle high; clock stands still between frames
   initial begin
      o_tck = 1'b1;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      o_trst_n = 1'b1;
   end

   // slow clock, inputs stable at rise
   task automatic step(input logic ms, input logic di, output logic dout);
      o_tms <= ms;
      o_tdi <= di;
      o_tck <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      // bit launched on last rise; undriven pin reads inverted
      dout = i_tdo_oe ? i_tdo : ~i_tdo;
      o_tck <= 1'b1;
      repeat (4) @(posedge i_core_clk);
   endtask : step

   task automatic scan(input logic ir, input int n, input logic [39:0] din,
                       output logic [39:0] dout);
      logic b;
      dout = '0;
      step(1'b0, 1'b1, b);
      step(1'b1, 1'b1, b);
      if (ir) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask : scan

   // twenty clocks low, also the retry path
   task automatic test_reset;
      logic b;
      o_trst_n <= 1'b0;
      repeat (20) step(1'b1, 1'b1, b);
      o_trst_n <= 1'b1;
      step(1'b0, 1'b1, b);
   endtask : test_reset

   task automatic tms_reset;
      logic b;
      repeat (5) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask : tms_reset
endmodule : jtag_host_model

/* verif/test_debug_mailbox_port.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_debug_mailbox_port;
   localparam logic [7:0] A_INS = {debug_port_pkg::IDX_INSTRUCTION, 2'b00};
   localparam logic [7:0] A_STS = {debug_port_pkg::IDX_STATUS, 2'b00};
   localparam logic [7:0] A_DH  = {debug_port_pkg::IDX_DATA_HIGH, 2'b00};
   localparam logic [7:0] A_DL  = {debug_port_pkg::IDX_DATA_LOW, 2'b00};
   localparam logic [7:0] A_STP = {debug_port_pkg::IDX_MODULE_STOP, 2'b00};
   localparam logic [3:0] C_IRQ = debug_port_pkg::CODE_DEBUG_IRQ;
   localparam logic [3:0] C_BYP = debug_port_pkg::CODE_BYPASS;
   logic        i_core_clk, i_arst_n, i_hw_standby, i_psel, i_penable;
   logic        i_pwrite, i_tck, i_tms, i_tdi, i_trst_n;
   logic        o_tdo, o_tdo_oe, o_debug_irq, o_pready, o_pslverr;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   int          n_errors, cmp_count, irq_cnt;

   debug_mailbox_port debug_mailbox_port_i (.i_core_clk, .i_arst_n, .i_tck,
      .i_tms, .i_tdi, .i_trst_n, .i_hw_standby, .o_tdo, .o_tdo_oe,
      .o_debug_irq, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr);
   jtag_host_model jtag_host_model_i (.i_core_clk, .i_tdo(o_tdo),
      .i_tdo_oe(o_tdo_oe), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
      .o_trst_n(i_trst_n));

   initial begin
      i_core_clk = 1'b0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end

   always @(posedge i_core_clk) begin
      if (o_debug_irq === 1'b1) irq_cnt <= irq_cnt + 1;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : cyc

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge i_core_clk);
      end while (o_pready !== 1'b1);
      r = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // idle edge so a following call never drives psel twice at once
      @(posedge i_core_clk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      `CHK($sformatf("reg %h", a), x, r)
      `CHK("slave error", (a > 8'h10 || a[1:0] != 2'h0), e)
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic give_verdict;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   initial begin
      cyc(40000);
      n_errors++;
      give_verdict();
   end

   initial begin
      logic [39:0] q;
      logic [39:0] d;
      d = 40'h039ABCDEF1;
      i_arst_n = 1'b0;
      i_hw_standby = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 8'h00;
      i_pwdata = 32'h00000000;
      cyc(12);
      i_arst_n <= 1'b1;
      cyc(3);
      jtag_host_model_i.test_reset();
      rd(A_INS, 32'h0000F000);
      rd(A_STS, 32'h00000201);
      rd(8'h14, 32'h00000000);
      rd(8'h05, 32'h00000000);
      wr(A_INS, 32'h00000000);
      rd(A_INS, 32'h0000F000);
      wr(A_STS, 32'h0000FDFE);
      rd(A_STS, 32'h00000201);
      wr(A_STS, 32'h00000001);
      // six bits in, last four kept
      jtag_host_model_i.scan(1'b1, 6, {34'h0, C_IRQ, 2'b11}, q);
      cyc(2);
      `CHK("irq count", 1, irq_cnt)
      rd(A_INS, {16'h0000, C_IRQ, 12'h000});
      wr(A_DH, 32'h00001234);
      wr(A_DL, 32'h00005678);
      jtag_host_model_i.scan(1'b0, 1, 40'h1, q);
      `CHK("flag out", 1'b1, q[0])
      jtag_host_model_i.scan(1'b0, 34, d, q);
      `CHK("data out", 32'h12345678, q[31:0])
      rd(A_STS, 32'h00000200);
      rd(A_DH, {16'h0000, d[33:18]});
      rd(A_DL, {16'h0000, d[17:2]});
      jtag_host_model_i.scan(1'b0, 2, 40'h3, q);
      `CHK("status out", 2'b00, q[1:0])
      rd(A_DL, {16'h0000, d[17:2]});
      // system reset mid-run leaves port state
      i_arst_n <= 1'b0;
      cyc(4);
      i_arst_n <= 1'b1;
      cyc(3);
      rd(A_STS, 32'h00000200);
      rd(A_DH, {16'h0000, d[33:18]});
      rd(A_INS, {16'h0000, C_IRQ, 12'h000});
      wr(A_STS, 32'h00000001);
      rd(A_STS, 32'h00000201);
      wr(A_STS, 32'h00000000);
      jtag_host_model_i.scan(1'b1, 4, {36'h0, C_BYP}, q);
      rd(A_STS, 32'h00000201);
      jtag_host_model_i.scan(1'b0, 3, 40'h5, q);
      `CHK("bypass out", 3'b010, q[2:0])
      // reserved code takes the one-stage path
      jtag_host_model_i.scan(1'b1, 4, 40'h0, q);
      rd(A_INS, 32'h00000000);
      jtag_host_model_i.scan(1'b0, 2, 40'h1, q);
      `CHK("reserved out", 2'b10, q[1:0])
      for (int m = 0; m < 3; m++) begin
         jtag_host_model_i.scan(1'b1, 4, {36'h0, C_IRQ}, q);
         if (m == 0) begin
            wr(A_STP, 32'h00000001);
            wr(A_STP, 32'h00000000);
         end else if (m == 1) begin
            jtag_host_model_i.tms_reset();
         end else begin
            i_hw_standby <= 1'b1;
            cyc(8);
            i_hw_standby <= 1'b0;
            cyc(4);
         end
         rd(A_INS, 32'h0000F000);
      end
      `CHK("irq count", 4, irq_cnt)
      jtag_host_model_i.test_reset();
      rd(A_DL, {16'h0000, d[17:2]});
      rd(A_STS, 32'h00000201);
      give_verdict();
   end
endmodule : test_debug_mailbox_port

bind debug_mailbox_port debug_mailbox_port_asserts
   debug_mailbox_port_asserts_i (.i_core_clk, .i_arst_n, .i_tck, .i_tms,
   .i_tdi, .i_trst_n, .i_hw_standby, .o_tdo, .o_tdo_oe, .o_debug_irq,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
   .o_pready, .o_pslverr);
